// file: deep_sleep_consts.svh
// constants for the deep sleep sequencer
`ifndef DEEP_SLEEP_CONSTS_SVH
`define DEEP_SLEEP_CONSTS_SVH

// ============================================================
// register word indices (compared with byte address bits 5:2)
`define ADDR_CONTROL 4'h0
`define ADDR_CONFIG 4'h1
`define ADDR_WAKE_LOW 4'h2
`define ADDR_WAKE_HIGH 4'h3
`define ADDR_WDT_CTRL 4'h4
`define ADDR_RESET_CTRL 4'h5
`define ADDR_CLOCK_STAT 4'h6

// ============================================================
// config byte three low fields
`define CFG_WDT_CLK_BIT 0
`define CFG_CAL_CLK_BIT 1
`define CFG_BOR_EN_BIT 2
`define CFG_WDT_EN_BIT 3
`define CFG_PS_LSB 4
`define CFG_RESET 8'hFF

// ============================================================
// wake source low-status bit positions
`define WAKE_PIN_BIT 0
`define WAKE_WDT_BIT 1
`define WAKE_CAL_BIT 2
`define WAKE_ULP_BIT 3
`define WAKE_BOR_BIT 4
`define WAKE_POR_BIT 5
// high status: external interrupt zero
`define WAKE_EXTERNAL_INTERRUPT_ZERO_BIT 0

// watchdog control reg: deep sleep exit flag
`define WDT_DS_BIT 3

// reset control reg flags (low five bits, active high here)
`define RST_BOR_BIT 0
`define RST_POR_BIT 1
`define RST_PD_BIT 2
`define RST_WDT_BIT 3
`define RST_INSTR_BIT 4

// ============================================================
// interrupt vectors
`define VEC_RESET 16'h0000
`define VEC_HIGH 16'h0008
`define VEC_LOW 16'h0018

// shortest watchdog time-out, microseconds
`define WDT_MIN_US 2100
`define CLK_MHZ 125
`define PS_STEPS 16

`endif

// file: deep_sleep_pkg.sv
// types for the deep sleep sequencer
package deep_sleep_pkg;
   typedef enum logic [4:0] {
      ST_RUN = 5'h01,
      ST_SECONDARY_CLOCK_RUN_MODE = 5'h02,
      ST_SWITCH = 5'h04,
      ST_DEEP = 5'h08,
      ST_WAKE_RST = 5'h10
   } pm_state_e;

   typedef enum logic [3:0] {
      RC_NONE = 4'h0,
      RC_POR = 4'h1,
      RC_PIN_RUN = 4'h2,
      RC_PIN_PM = 4'h3,
      RC_WDT = 4'h4,
      RC_CFG_MISMATCH = 4'h5,
      RC_BOR = 4'h6,
      RC_INSTR = 4'h7,
      RC_STACK_FULL = 4'h8,
      RC_STACK_UNDER = 4'h9,
      RC_DEEP = 4'hA
   } reset_cause_e;
endpackage

// file: deep_sleep_wake_reset.sv
// deep sleep wake sequencer, watchdog and reset-cause tracking
// ============================================================
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "deep_sleep_consts.svh"

module deep_sleep_wake_reset
   import deep_sleep_pkg::*;
#(
   parameter int WDT_BASE_CYCLES = (`WDT_MIN_US * `CLK_MHZ)
) (
   input wire logic mclk,
   input wire logic srst,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // asynchronous wake and reset event pins
   input wire logic master_clear_pin,
   input wire logic por_event,
   input wire logic bor_event,
   input wire logic calendar_alarm,
   input wire logic external_interrupt_zero,
   input wire logic ultra_low_power_wake,
   // events from the core and the oscillators, same clock
   input wire logic sleep_req,
   input wire logic irq_pending,
   input wire logic irq_high,
   input wire logic global_high_irq_enable,
   input wire logic global_low_irq_enable,
   input wire logic [15:0] pc_in,
   input wire logic wdt_reset_event,
   input wire logic cfg_mismatch_event,
   input wire logic reset_instr_event,
   input wire logic stack_full_event,
   input wire logic stack_under_event,
   input wire logic primary_ready,
   input wire logic rc_tick,
   input wire logic sec_tick,
   // outputs
   output logic core_reset,
   output logic [15:0] pc_load,
   output logic pc_load_en,
   output logic [15:0] stack_push_data,
   output logic stack_push_en,
   output logic primary_clock_run_mode,
   output logic secondary_osc_enable,
   output logic calendar_tick,
   output logic deep_sleep_brownout_detector,
   output logic sleep_abort,
   output logic [3:0] reset_cause
);

   // ============================================================
   // pin synchronisers: three stages, change accepted when 2 and 3 agree
   localparam int NPIN = 6;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q, pin_d;
   assign pin_raw = {bor_event, ultra_low_power_wake, external_interrupt_zero,
                     calendar_alarm, por_event, master_clear_pin};

   always_comb begin
      pin_d = pin_q;
      for (int i = 0; i < NPIN; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            pin_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         pin_q <= '0;
      end else begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_q <= pin_d;
      end
   end

   logic master_clear_pin_s, por_s, alarm_s, external_interrupt_zero_s, ulp_s, bor_s;
   assign {bor_s, ulp_s, external_interrupt_zero_s, alarm_s, por_s, master_clear_pin_s} = pin_q;

   // ============================================================
   // register state
   logic [7:0] config_byte_three_low_q, config_byte_three_low_d;
   logic idle_on_sleep_enable_q, idle_on_sleep_enable_d;
   logic [1:0] system_clock_select_q, system_clock_select_d;
   logic sec_osc_en_q, sec_osc_en_d;
   logic leave_sec_q, leave_sec_d;
   logic [7:0] wake_source_status_low_q, wake_source_status_low_d;
   logic [7:0] wake_source_status_high_q, wake_source_status_high_d;
   logic deep_sleep_exit_flag_q, deep_sleep_exit_flag_d;
   logic [4:0] reset_control_reg_q, reset_control_reg_d;
   logic secondary_clock_active_flag_q, secondary_clock_active_flag_d;
   logic osc_startup_done_flag_q, osc_startup_done_flag_d;
   pm_state_e state_q, state_d;
   reset_cause_e cause_q, cause_d;
   logic [31:0] wdt_pre_q, wdt_pre_d;
   logic [3:0] wdt_post_q, wdt_post_d;
   logic [31:0] dat_q, dat_d;
   logic ack_q, ack_d;
   logic core_rst_q, core_rst_d;
   logic [15:0] pc_q, pc_d, push_q, push_d;
   logic pc_en_q, pc_en_d, push_en_q, push_en_d, abort_q, abort_d;
   logic cal_tick_q, cal_tick_d, bor_act_q, bor_act_d;

   logic wr, rd, wdt_tick, wdt_expire, any_wake;
   logic [5:0] wake_vec;
   logic [3:0] ps_sel;
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q & wb_sel_i[0];
   assign rd = wb_cyc_i & wb_stb_i & ~ack_q;
   assign ps_sel = config_byte_three_low_q[`CFG_PS_LSB +: 4];
   assign wdt_tick = config_byte_three_low_q[`CFG_WDT_CLK_BIT] ? sec_tick : rc_tick;
   assign wdt_expire = config_byte_three_low_q[`CFG_WDT_EN_BIT] &&
                       (wdt_post_q >= ps_sel) && (wdt_pre_q == WDT_BASE_CYCLES - 1);
   assign wake_vec = {ulp_s, wdt_expire, external_interrupt_zero_s, alarm_s, por_s, master_clear_pin_s};
   assign any_wake = |wake_vec;

   // ============================================================
   // next-state logic
   always_comb begin
      config_byte_three_low_d = config_byte_three_low_q;
      idle_on_sleep_enable_d = idle_on_sleep_enable_q;
      system_clock_select_d = system_clock_select_q;
      sec_osc_en_d = sec_osc_en_q;
      leave_sec_d = 1'b0;
      wake_source_status_low_d = wake_source_status_low_q;
      wake_source_status_high_d = wake_source_status_high_q;
      deep_sleep_exit_flag_d = deep_sleep_exit_flag_q;
      reset_control_reg_d = reset_control_reg_q;
      secondary_clock_active_flag_d = secondary_clock_active_flag_q;
      osc_startup_done_flag_d = osc_startup_done_flag_q;
      state_d = state_q;
      cause_d = cause_q;
      wdt_pre_d = wdt_pre_q;
      wdt_post_d = wdt_post_q;
      core_rst_d = 1'b0;
      pc_d = pc_q;
      pc_en_d = 1'b0;
      push_d = push_q;
      push_en_d = 1'b0;
      abort_d = 1'b0;
      cal_tick_d = config_byte_three_low_q[`CFG_CAL_CLK_BIT] ? sec_tick : rc_tick;
      bor_act_d = (state_q == ST_DEEP) && config_byte_three_low_q[`CFG_BOR_EN_BIT];
      ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
      dat_d = 32'h0000_0000;

      // software writes; hardware sets below override clears
      if (wr) begin
         case (wb_adr_i[5:2])
            `ADDR_CONTROL: begin
               idle_on_sleep_enable_d = wb_dat_i[0];
               system_clock_select_d = wb_dat_i[2:1];
               sec_osc_en_d = wb_dat_i[3];
               leave_sec_d = wb_dat_i[4];
            end
            `ADDR_CONFIG: config_byte_three_low_d = wb_dat_i[7:0];
            `ADDR_WDT_CTRL: begin
               if (!wb_dat_i[`WDT_DS_BIT]) begin
                  deep_sleep_exit_flag_d = 1'b0;
               end
            end
            `ADDR_RESET_CTRL: reset_control_reg_d = reset_control_reg_q & wb_dat_i[4:0];
            default: ;
         endcase
      end

      if (rd) begin
         case (wb_adr_i[5:2])
            `ADDR_CONTROL: dat_d = {28'h0, sec_osc_en_q, system_clock_select_q,
                                    idle_on_sleep_enable_q};
            `ADDR_CONFIG: dat_d = {24'h0, config_byte_three_low_q};
            `ADDR_WAKE_LOW: dat_d = {24'h0, wake_source_status_low_q};
            `ADDR_WAKE_HIGH: dat_d = {24'h0, wake_source_status_high_q};
            `ADDR_WDT_CTRL: dat_d = {28'h0, deep_sleep_exit_flag_q, 3'h0};
            `ADDR_RESET_CTRL: dat_d = {23'h0, cause_q, reset_control_reg_q};
            `ADDR_CLOCK_STAT: dat_d = {29'h0, state_q == ST_RUN,
                                       osc_startup_done_flag_q,
                                       secondary_clock_active_flag_q};
            default: dat_d = 32'h0000_0000;
         endcase
      end

      // run-time reset events
      if (wdt_reset_event) begin
         reset_control_reg_d[`RST_WDT_BIT] = 1'b1;
         cause_d = RC_WDT;
      end
      if (cfg_mismatch_event) cause_d = RC_CFG_MISMATCH;
      if (stack_full_event) cause_d = RC_STACK_FULL;
      if (stack_under_event) cause_d = RC_STACK_UNDER;
      if (reset_instr_event) begin
         reset_control_reg_d[`RST_INSTR_BIT] = 1'b1;
         cause_d = RC_INSTR;
      end
      if (bor_s && state_q != ST_DEEP) begin
         reset_control_reg_d[`RST_BOR_BIT] = 1'b1;
         cause_d = RC_BOR;
      end
      if (master_clear_pin_s && state_q != ST_DEEP) begin
         cause_d = (state_q == ST_SECONDARY_CLOCK_RUN_MODE || state_q == ST_SWITCH) ? RC_PIN_PM : RC_PIN_RUN;
      end

      // watchdog postscaler: tick count chained into postscale stages
      if (state_q == ST_DEEP && config_byte_three_low_q[`CFG_WDT_EN_BIT] && wdt_tick) begin
         if (wdt_pre_q == WDT_BASE_CYCLES - 1) begin
            wdt_pre_d = 32'h0;
            if (wdt_post_q < ps_sel) wdt_post_d = wdt_post_q + 4'h1;
         end else begin
            wdt_pre_d = wdt_pre_q + 32'h1;
         end
      end

      case (state_q)
         ST_RUN: begin
            if (system_clock_select_d == 2'h1 && system_clock_select_q != 2'h1) begin
               state_d = ST_SECONDARY_CLOCK_RUN_MODE;
               secondary_clock_active_flag_d = 1'b1;
               osc_startup_done_flag_d = 1'b0;
            end
            if (sleep_req) begin
               if (irq_pending) begin
                  abort_d = 1'b1;
               end else begin
                  state_d = ST_DEEP;
                  wake_source_status_low_d = 8'h00;
                  wake_source_status_high_d = 8'h00;
                  wdt_pre_d = 32'h0;
                  wdt_post_d = 4'h0;
               end
            end
         end
         ST_SECONDARY_CLOCK_RUN_MODE: begin
            if (leave_sec_q) state_d = ST_SWITCH;
         end
         ST_SWITCH: begin
            // stay on secondary clock until primary is ready
            if (primary_ready) begin
               state_d = ST_RUN;
               secondary_clock_active_flag_d = 1'b0;
               osc_startup_done_flag_d = 1'b1;
               // idle, select and osc enable untouched
               if (irq_pending && (global_high_irq_enable || global_low_irq_enable)) begin
                  push_d = pc_in;
                  push_en_d = 1'b1;
                  pc_d = irq_high ? `VEC_HIGH : `VEC_LOW;
                  pc_en_d = 1'b1;
               end
            end
         end
         ST_DEEP: begin
            // logging only here, so events before entry never show
            if (any_wake) begin
               wake_source_status_low_d[`WAKE_PIN_BIT] = master_clear_pin_s;
               wake_source_status_low_d[`WAKE_POR_BIT] = por_s & ~master_clear_pin_s;
               wake_source_status_low_d[`WAKE_CAL_BIT] = alarm_s & ~|wake_vec[1:0];
               wake_source_status_high_d[`WAKE_EXTERNAL_INTERRUPT_ZERO_BIT] = external_interrupt_zero_s & ~|wake_vec[2:0];
               wake_source_status_low_d[`WAKE_WDT_BIT] = wdt_expire & ~|wake_vec[3:0];
               wake_source_status_low_d[`WAKE_ULP_BIT] = ulp_s & ~|wake_vec[4:0];
               state_d = ST_WAKE_RST;
            end else if (bor_s && config_byte_three_low_q[`CFG_BOR_EN_BIT]) begin
               wake_source_status_low_d[`WAKE_BOR_BIT] = 1'b1;
               state_d = ST_WAKE_RST;
            end
         end
         ST_WAKE_RST: begin
            // full power-on reset; wake flags kept
            core_rst_d = 1'b1;
            pc_d = `VEC_RESET;
            pc_en_d = 1'b1;
            deep_sleep_exit_flag_d = 1'b1;
            reset_control_reg_d[`RST_POR_BIT] = 1'b1;
            reset_control_reg_d[`RST_PD_BIT] = 1'b1;
            cause_d = RC_DEEP;
            state_d = ST_RUN;
         end
         default: state_d = ST_RUN;
      endcase
   end

   // ============================================================
   // registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         config_byte_three_low_q <= `CFG_RESET;
         idle_on_sleep_enable_q <= 1'b0;
         system_clock_select_q <= 2'h0;
         sec_osc_en_q <= 1'b0;
         leave_sec_q <= 1'b0;
         wake_source_status_low_q <= 8'h00;
         wake_source_status_high_q <= 8'h00;
         deep_sleep_exit_flag_q <= 1'b0;
         reset_control_reg_q <= 5'h02;
         secondary_clock_active_flag_q <= 1'b0;
         osc_startup_done_flag_q <= 1'b1;
         state_q <= ST_RUN;
         cause_q <= RC_POR;
         wdt_pre_q <= 32'h0;
         wdt_post_q <= 4'h0;
         dat_q <= 32'h0;
         ack_q <= 1'b0;
         core_rst_q <= 1'b0;
         pc_q <= `VEC_RESET;
         pc_en_q <= 1'b0;
         push_q <= 16'h0000;
         push_en_q <= 1'b0;
         abort_q <= 1'b0;
         cal_tick_q <= 1'b0;
         bor_act_q <= 1'b0;
      end else begin
         config_byte_three_low_q <= config_byte_three_low_d;
         idle_on_sleep_enable_q <= idle_on_sleep_enable_d;
         system_clock_select_q <= system_clock_select_d;
         sec_osc_en_q <= sec_osc_en_d;
         leave_sec_q <= leave_sec_d;
         wake_source_status_low_q <= wake_source_status_low_d;
         wake_source_status_high_q <= wake_source_status_high_d;
         deep_sleep_exit_flag_q <= deep_sleep_exit_flag_d;
         reset_control_reg_q <= reset_control_reg_d;
         secondary_clock_active_flag_q <= secondary_clock_active_flag_d;
         osc_startup_done_flag_q <= osc_startup_done_flag_d;
         state_q <= state_d;
         cause_q <= cause_d;
         wdt_pre_q <= wdt_pre_d;
         wdt_post_q <= wdt_post_d;
         dat_q <= dat_d;
         ack_q <= ack_d;
         core_rst_q <= core_rst_d;
         pc_q <= pc_d;
         pc_en_q <= pc_en_d;
         push_q <= push_d;
         push_en_q <= push_en_d;
         abort_q <= abort_d;
         cal_tick_q <= cal_tick_d;
         bor_act_q <= bor_act_d;
      end
   end

   assign wb_dat_o = dat_q;
   assign wb_ack_o = ack_q;
   assign core_reset = core_rst_q;
   assign pc_load = pc_q;
   assign pc_load_en = pc_en_q;
   assign stack_push_data = push_q;
   assign stack_push_en = push_en_q;
   assign secondary_osc_enable = sec_osc_en_q;
   assign calendar_tick = cal_tick_q;
   assign deep_sleep_brownout_detector = bor_act_q;
   assign sleep_abort = abort_q;
   assign reset_cause = cause_q;

   // registered run flag
   logic prim_q;
   always_ff @(posedge mclk) begin
      if (srst) begin
         prim_q <= 1'b1;
      end else begin
         prim_q <= (state_d == ST_RUN);
      end
   end
   assign primary_clock_run_mode = prim_q;

endmodule // deep_sleep_wake_reset
`default_nettype wire

// file: deep_sleep_wake_reset_asserts.sv
// port checks for the deep sleep sequencer
`timescale 1ns/1ps
`default_nettype none
`include "deep_sleep_consts.svh"
module deep_sleep_wake_reset_asserts #(
   parameter int WDT_BASE_CYCLES = 4
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic sleep_req,
   input wire logic irq_pending,
   input wire logic rc_tick,
   input wire logic sec_tick,
   input wire logic core_reset,
   input wire logic [15:0] pc_load,
   input wire logic pc_load_en,
   input wire logic stack_push_en,
   input wire logic primary_clock_run_mode,
   input wire logic calendar_tick,
   input wire logic deep_sleep_brownout_detector,
   input wire logic sleep_abort
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // ==========
   // steps
   sequence bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence sleep_blocked;
      sleep_req && irq_pending && primary_clock_run_mode;
   endsequence
   sequence abort_pulse;
      sleep_abort ##1 !sleep_abort;
   endsequence
   // ==========
   // checks
   bus_answer_a: assert property (bus_req |=> wb_ack_o)
      else $error("no ack");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held");
   unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[5:2] > 4'h6 |-> wb_dat_o == 32'h0)
      else $error("unmapped nonzero");
   entry_abort_a: assert property (sleep_blocked |=> abort_pulse)
      else $error("no abort");
   wake_vector_a: assert property (core_reset |-> pc_load_en && pc_load == `VEC_RESET)
      else $error("bad reset vector");
   wake_origin_a: assert property (core_reset |-> !$past(primary_clock_run_mode, 2) ##1 !core_reset)
      else $error("stray wake");
   push_vector_a: assert property (stack_push_en |-> pc_load_en && (pc_load == `VEC_HIGH || pc_load == `VEC_LOW))
      else $error("bad push vector");
   bor_sleep_a: assert property (deep_sleep_brownout_detector |-> !primary_clock_run_mode)
      else $error("bor outside sleep");
   cal_source_a: assert property (calendar_tick |-> $past(rc_tick) || $past(sec_tick))
      else $error("stray cal tick");
endmodule // deep_sleep_wake_reset_asserts
`default_nettype wire

// file: wake_event_model.sv
// far side: slow ticks, warm-up, wake pins
`timescale 1ns/1ps
`default_nettype none
module wake_event_model #(
   parameter int RC_DIV = 3,
   parameter int SEC_DIV = 8,
   parameter int WARM_CYCLES = 12
) (
   input wire logic mclk,
   input wire logic warm_req,
   output logic rc_tick,
   output logic sec_tick,
   output logic primary_ready,
   output logic [4:0] wake_pins
);
   int rc_n = 0;
   int sec_n = 0;
   int warm_n = 0;
   initial begin
      {rc_tick, sec_tick, primary_ready} = 3'b000;
      wake_pins = 5'h00;
   end
   // ==========
   // oscillators; primary ready after warm-up
   always @(posedge mclk) begin
      rc_n <= (rc_n + 1) % RC_DIV;
      sec_n <= (sec_n + 1) % SEC_DIV;
      rc_tick <= (rc_n == 0);
      sec_tick <= (sec_n == 0);
      warm_n <= warm_req ? warm_n + 1 : 0;
      primary_ready <= warm_req && (warm_n >= WARM_CYCLES);
   end
   task automatic raise(input int i);
      @(posedge mclk);
      wake_pins[i] <= 1'b1;
   endtask
   task automatic drop_all();
      @(posedge mclk);
      wake_pins <= 5'h00;
   endtask
endmodule // wake_event_model
`default_nettype wire

// file: deep_sleep_wake_reset_tb.sv
// bench for the deep sleep sequencer
`timescale 1ns/1ps
`default_nettype none
`include "deep_sleep_consts.svh"
module deep_sleep_wake_reset_tb import deep_sleep_pkg::*; ();
   localparam int WDT_BASE = 4;
   logic mclk = 0, srst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, warm = 0;
   logic [5:0] wb_adr_i = 6'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat, rnd = 32'h822B;
   logic sleep_req = 0, irq_pending = 0, irq_high = 0;
   logic global_high_irq_enable = 0, global_low_irq_enable = 0;
   logic [15:0] pc_in = 16'h0, pc_load, stack_push_data, pushed, vec;
   logic [4:0] core_ev = 5'h00, wake_pins, exp_flags;
   logic [3:0] reset_cause;
   logic [1:0] ps;
   logic [63:0] exp_w;
   logic wb_ack_o, core_reset, pc_load_en, stack_push_en, primary_clock_run_mode, abort_seen = 0;
   logic secondary_osc_enable, calendar_tick, deep_sleep_brownout_detector, sleep_abort;
   logic rc_tick, sec_tick, primary_ready;
   wire logic master_clear_pin, por_event, calendar_alarm, external_interrupt_zero;
   wire logic ultra_low_power_wake, wdt_reset_event, cfg_mismatch_event;
   wire logic reset_instr_event, stack_full_event, stack_under_event;
   int failures = 0, n_tests = 0, cal_cnt = 0, n, j, c0, lo, hi;
   int comp [4] = '{0, 2, 3, 4};
   reset_cause_e causes [5] = '{RC_WDT, RC_CFG_MISMATCH, RC_INSTR, RC_STACK_FULL, RC_STACK_UNDER};
   assign {ultra_low_power_wake, external_interrupt_zero, calendar_alarm, por_event,
      master_clear_pin} = wake_pins;
   assign {stack_under_event, stack_full_event, reset_instr_event, cfg_mismatch_event,
      wdt_reset_event} = core_ev;
   deep_sleep_wake_reset #(.WDT_BASE_CYCLES(WDT_BASE)) u_deep_sleep_wake_reset (.mclk, .srst,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
      .master_clear_pin, .por_event, .bor_event(1'b0), .calendar_alarm, .external_interrupt_zero,
      .ultra_low_power_wake, .sleep_req, .irq_pending, .irq_high, .global_high_irq_enable,
      .global_low_irq_enable, .pc_in, .wdt_reset_event, .cfg_mismatch_event, .reset_instr_event,
      .stack_full_event, .stack_under_event, .primary_ready, .rc_tick, .sec_tick, .core_reset,
      .pc_load, .pc_load_en, .stack_push_data, .stack_push_en, .primary_clock_run_mode,
      .secondary_osc_enable, .calendar_tick, .deep_sleep_brownout_detector, .sleep_abort,
      .reset_cause);
   wake_event_model #(.RC_DIV(3), .SEC_DIV(8), .WARM_CYCLES(12)) u_wake_event_model (.mclk,
      .warm_req(warm), .rc_tick, .sec_tick, .primary_ready, .wake_pins);
   // ==========
   // helpers
   function automatic logic [31:0] next_rand();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction
   function automatic logic [63:0] wake_exp(input int i);
      int pos [5] = '{`WAKE_PIN_BIT, `WAKE_POR_BIT, `WAKE_CAL_BIT, 0, `WAKE_ULP_BIT};
      return (i == 3) ? (64'h1_0000_0000 << `WAKE_EXTERNAL_INTERRUPT_ZERO_BIT) : (64'h1 << pos[i]);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge mclk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 2'b00, 4'hF, d};
      do begin
         @(posedge mclk);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      rdat = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      if (k >= 50) chk(0, 1, "bus timeout");
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
      bus(a, 1'b0, 32'h0);
      chk(rdat, exp, what);
   endtask
   task automatic pulse_sleep();
      @(posedge mclk);
      sleep_req <= 1'b1;
      @(posedge mclk);
      sleep_req <= 1'b0;
   endtask
   task automatic wait_wake(output int c);
      c = 0;
      do begin
         @(posedge mclk);
         c++;
      end while (core_reset !== 1'b1 && c < 400);
      if (c >= 400) chk(0, 1, "no wake");
   endtask
   task automatic close_out();
      $display("failures=%0d comparisons=%0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ==========
   // clock, monitors, watchdog
   initial forever #4 mclk = ~mclk;
   always @(negedge mclk) begin
      if (calendar_tick === 1'b1) cal_cnt++;
      if (sleep_abort === 1'b1) abort_seen = 1'b1;
      if (stack_push_en === 1'b1) {pushed, vec} = {stack_push_data, pc_load};
   end
   initial begin
      #200000;
      chk(0, 1, "timeout");
      close_out();
   end
   // ==========
   // scenarios
   initial begin
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      rd(`ADDR_CONFIG, {24'h0, `CFG_RESET}, "cfg reset");
      rd(`ADDR_RESET_CTRL, 32'h22, "rst reset");
      rd(`ADDR_CLOCK_STAT, 32'h6, "stat reset");
      bus(4'h9, 1'b1, next_rand());
      rd(4'h9, 32'h0, "unmapped");
      bus(`ADDR_RESET_CTRL, 1'b1, 32'h1D);
      exp_flags = 5'h00;
      for (int i = 0; i < 5; i++) begin
         @(posedge mclk);
         core_ev <= 5'h01 << i;
         @(posedge mclk);
         core_ev <= 5'h00;
         if (i == 0) exp_flags[`RST_WDT_BIT] = 1'b1;
         if (i == 2) exp_flags[`RST_INSTR_BIT] = 1'b1;
         bus(`ADDR_RESET_CTRL, 1'b0, 32'h0);
         chk(rdat[8:0], {causes[i], exp_flags}, "causes");
      end
      // secondary run and return
      bus(`ADDR_CONTROL, 1'b1, 32'h0A);
      rd(`ADDR_CLOCK_STAT, 32'h1, "secondary_clock_run_mode");
      void'(next_rand());
      pc_in <= rnd[15:0];
      {irq_pending, irq_high, global_high_irq_enable} <= 3'b111;
      bus(`ADDR_CONTROL, 1'b1, 32'h1A);
      repeat (20) @(posedge mclk);
      chk(primary_clock_run_mode, 0, "early switch");
      warm <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (primary_clock_run_mode !== 1'b1 && n < 100);
      repeat (2) @(posedge mclk);
      chk({pushed, vec}, {pc_in, `VEC_HIGH}, "push");
      irq_pending <= 1'b0;
      rd(`ADDR_CLOCK_STAT, 32'h6, "switch flags");
      rd(`ADDR_CONTROL, 32'h0A, "kept");
      chk(secondary_osc_enable, 1, "osc kept");
      irq_pending <= 1'b1;
      pulse_sleep();
      repeat (3) @(posedge mclk);
      chk({abort_seen, primary_clock_run_mode}, 2'b11, "abort");
      irq_pending <= 1'b0;
      for (int s = 0; s < 2; s++) begin
         bus(`ADDR_CONFIG, 1'b1, 32'(s << `CFG_CAL_CLK_BIT));
         c0 = cal_cnt;
         repeat (96) @(posedge mclk);
         chk(cal_cnt - c0, s ? 12 : 32, "cal rate");
      end
      // watchdog wake
      void'(next_rand());
      ps = rnd[1:0];
      bus(`ADDR_CONFIG, 1'b1, {24'h0, 2'b00, ps, 4'h9});
      pulse_sleep();
      repeat (2) @(posedge mclk);
      chk(deep_sleep_brownout_detector, 0, "bor off");
      wait_wake(n);
      lo = (WDT_BASE * (ps + 1) - 1) * 8 - 6;
      hi = WDT_BASE * (ps + 1) * 8 + 4;
      chk(32'(n >= lo && n <= hi), 1, "wdt time");
      rd(`ADDR_WAKE_LOW, 32'h1 << `WAKE_WDT_BIT, "wdt log");
      rd(`ADDR_WDT_CTRL, 32'h8, "exit set");
      chk(reset_cause, RC_DEEP, "ds cause");
      // each source, early decoy, later rival
      bus(`ADDR_CONFIG, 1'b1, 32'h04);
      for (int i = 0; i < 5; i++) begin
         void'(next_rand());
         j = (comp[rnd % 4] == i) ? comp[(rnd + 1) % 4] : comp[rnd % 4];
         bus(`ADDR_WDT_CTRL, 1'b1, 32'h0);
         rd(`ADDR_WDT_CTRL, 32'h0, "exit clr");
         u_wake_event_model.raise(j);
         repeat (3) @(posedge mclk);
         u_wake_event_model.drop_all();
         repeat (8) @(posedge mclk);
         pulse_sleep();
         repeat (2) @(posedge mclk);
         chk(deep_sleep_brownout_detector, 1, "bor on");
         rd(`ADDR_WAKE_LOW, 32'h0, "low clr");
         rd(`ADDR_WAKE_HIGH, 32'h0, "high clr");
         u_wake_event_model.raise(i);
         u_wake_event_model.raise(j);
         wait_wake(n);
         u_wake_event_model.drop_all();
         exp_w = wake_exp(i);
         rd(`ADDR_WAKE_LOW, exp_w[31:0], "first low");
         rd(`ADDR_WAKE_HIGH, exp_w[63:32], "first high");
         rd(`ADDR_WDT_CTRL, 32'h8, "exit wake");
      end
      close_out();
   end
endmodule // deep_sleep_wake_reset_tb
bind deep_sleep_wake_reset deep_sleep_wake_reset_asserts #(.WDT_BASE_CYCLES(WDT_BASE_CYCLES))
   u_deep_sleep_wake_reset_asserts (.mclk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o, .sleep_req, .irq_pending, .rc_tick, .sec_tick, .core_reset, .pc_load,
   .pc_load_en, .stack_push_en, .primary_clock_run_mode, .calendar_tick,
   .deep_sleep_brownout_detector, .sleep_abort);
`default_nettype wire
